// file: hw/eas_pkg.sv
// constants for the event/action sequencer
`default_nettype none
package eas_pkg;
  localparam int unsigned PAIRS_MAX = 20;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned CODE_W = 6;
  // event selector codes
  localparam logic [5:0] EV_FALSE = 6'h00;
  localparam logic [5:0] EV_TRUE = 6'h01;
  localparam logic [5:0] EV_ON_REF = 6'h04;
  localparam logic [5:0] EV_TIMEOUT0 = 6'h1e;
  // action selector codes
  localparam logic [5:0] AC_NONE = 6'h01;
  localparam logic [5:0] AC_PRESET0 = 6'h0a;
  localparam logic [5:0] AC_PRESET1 = 6'h0b;
  localparam logic [5:0] AC_TIMER0_START = 6'h1d;
  // command input function codes
  localparam logic [3:0] IN1_START = 4'h8;
  localparam logic [3:0] IN1_LATCHED = 4'h9;
  localparam logic [3:0] IN2_NOOP = 4'h0;
  localparam logic [3:0] IN2_STOP_INV = 4'h6;
  localparam logic [3:0] IN2_COAST_INV = 4'h2;
  // timing
  localparam int unsigned CLOCK_HZ = 200000000;
  localparam int unsigned SCAN_NS = 1000;
  localparam int unsigned SCAN_CYC = SCAN_NS / 5;
  localparam int unsigned TIMER_UNIT_MS = 1;
  localparam int unsigned TIMER_DEF_MS = 2000;
  localparam int unsigned SCAN_W = 16;
endpackage
`default_nettype wire

// file: hw/eas_top.sv
// event/action sequencer with start/stop command input selection
// ----------------------------------------------------------------
// Operation
// ----------------------------------------------------------------
// Operation
// - the program is a list of numbered pairs joining one event code to one action code.
// - when the current pair's event is true its action runs and the next pair is tested.
// - one event is tested per scan tick and a false one does nothing that tick.
// - after start only pair one is tested until it is found true.
// - the sequence length is programmable from zero to twenty pairs.
// - after the last pair's action the sequence restarts at pair one.
// - event codes are always true 1, on reference 4, timer zero out 30, always false 0.
// - action codes are preset zero 10, preset one 11, start timer zero 29, none 1.
// - timer zero is armed by its action and reports timeout after its programmed time.
// - the sequence runs only while the sequencer mode input is on.
// - a stop level on the command input ramps the motor down and then lets it coast.
// - command input one accepts start 8 and latched start 9.
// - command input two accepts no operation 0, stop inverse 6 and coast inverse 2.
`default_nettype none
module eas_top #(
  parameter int unsigned PAIRS = eas_pkg::PAIRS_MAX,
  parameter int unsigned SCAN_CYC = eas_pkg::SCAN_CYC,
  parameter int unsigned MS_CYC = eas_pkg::CLOCK_HZ / 1000,
  parameter logic [15:0] TIMER_DEF_MS = 16'(eas_pkg::TIMER_DEF_MS)
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // program port
  input wire logic [4:0] prog_addr,
  input wire logic [5:0] prog_event,
  input wire logic [5:0] prog_action,
  input wire logic prog_we,
  // settings
  input wire logic mode_on,
  input wire logic [4:0] seq_len,
  input wire logic [15:0] timer0_ms,
  input wire logic [3:0] in1_func,
  input wire logic [3:0] in2_func,
  // command inputs and drive status
  input wire logic cmd_in1,
  input wire logic cmd_in2,
  input wire logic at_reference,
  // drive controls and sequencer status
  output logic run_req,
  output logic ramp_down,
  output logic coast,
  output logic preset_sel,
  output logic [4:0] cur_pair,
  output logic timer0_expired,
  output logic scan_tick
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // program memory
  // ----------------------------------------------------------------
  logic [5:0] ev_mem [PAIRS];
  logic [5:0] ac_mem [PAIRS];
  always_ff @(posedge clock) begin
    if (prog_we && (32'(prog_addr) < PAIRS)) begin
      ev_mem[prog_addr] <= prog_event;
      ac_mem[prog_addr] <= prog_action;
    end
  end

  // ----------------------------------------------------------------
  // scan tick
  // ----------------------------------------------------------------
  logic [15:0] scan_cnt_reg, scan_cnt_next;
  logic tick_reg, tick_next;
  always_comb begin
    tick_next = 1'b0;
    scan_cnt_next = scan_cnt_reg + 16'h0001;
    if (32'(scan_cnt_reg) >= SCAN_CYC - 1) begin
      scan_cnt_next = 16'h0000;
      tick_next = 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scan_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      scan_cnt_reg <= scan_cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign scan_tick = tick_reg;

  // ----------------------------------------------------------------
  // command inputs
  // ----------------------------------------------------------------
  logic latch_reg, latch_next;
  logic stop_lvl, coast_lvl, start_lvl;
  always_comb begin
    stop_lvl = (in2_func == eas_pkg::IN2_STOP_INV) && !cmd_in2;
    coast_lvl = (in2_func == eas_pkg::IN2_COAST_INV) && !cmd_in2;
    latch_next = latch_reg;
    if (in1_func != eas_pkg::IN1_LATCHED || stop_lvl || coast_lvl) begin
      latch_next = 1'b0;
    end else if (cmd_in1) begin
      latch_next = 1'b1;
    end
    if (in1_func == eas_pkg::IN1_LATCHED) begin
      start_lvl = latch_reg;
    end else if (in1_func == eas_pkg::IN1_START) begin
      start_lvl = cmd_in1;
    end else begin
      start_lvl = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EAS_IDLE = 2'h0,
    EAS_RUN = 2'h1,
    EAS_RAMP = 2'h3,
    EAS_FREE = 2'h2
  } eas_state_type;
  eas_state_type st_reg, st_next;
  logic [4:0] idx_reg, idx_next;
  logic preset_reg, preset_next;
  logic [47:0] tcnt_reg, tcnt_next;
  logic tact_reg, tact_next;
  logic tdone_reg, tdone_next;
  logic ev_true;
  logic [5:0] cur_ev, cur_ac;
  logic [47:0] tgoal; // long ms settings times cycles per ms overflow 32 bits

  assign tgoal = 48'(timer0_ms) * 48'(MS_CYC);
  assign cur_ev = ev_mem[idx_reg];
  assign cur_ac = ac_mem[idx_reg];

  always_comb begin
    if (cur_ev == eas_pkg::EV_TRUE) begin
      ev_true = 1'b1;
    end else if (cur_ev == eas_pkg::EV_ON_REF) begin
      ev_true = at_reference;
    end else if (cur_ev == eas_pkg::EV_TIMEOUT0) begin
      ev_true = tdone_reg;
    end else begin
      ev_true = 1'b0; // false never advances
    end
  end

  always_comb begin
    st_next = st_reg;
    idx_next = idx_reg;
    preset_next = preset_reg;
    tact_next = tact_reg;
    tdone_next = tdone_reg;
    tcnt_next = tcnt_reg;
    if (tact_reg) begin
      if (tcnt_reg + 48'h1 >= tgoal) begin
        tact_next = 1'b0;
        tdone_next = 1'b1;
      end else begin
        tcnt_next = tcnt_reg + 48'h1;
      end
    end
    case (st_reg)
      EAS_IDLE: begin
        idx_next = 5'h00;
        if (mode_on && start_lvl) begin
          st_next = EAS_RUN;
        end
      end
      EAS_RUN: begin
        if (!mode_on) begin
          st_next = EAS_IDLE;
        end else if (stop_lvl || !start_lvl) begin
          st_next = EAS_RAMP;
        end else if (tick_reg && seq_len != 5'h00 && ev_true) begin
          if (cur_ac == eas_pkg::AC_PRESET0) begin
            preset_next = 1'b0;
          end else if (cur_ac == eas_pkg::AC_PRESET1) begin
            preset_next = 1'b1;
          end else if (cur_ac == eas_pkg::AC_TIMER0_START) begin
            tact_next = 1'b1;
            tdone_next = 1'b0;
            tcnt_next = 48'h0;
          end
          if (cur_ev == eas_pkg::EV_TIMEOUT0) begin
            tdone_next = 1'b0;
          end
          if (32'(idx_reg) + 1 >= 32'(seq_len) || 32'(idx_reg) + 1 >= PAIRS) begin
            idx_next = 5'h00;
          end else begin
            idx_next = idx_reg + 5'h01;
          end
        end
      end
      EAS_RAMP: begin
        if (!at_reference || preset_reg) begin
          st_next = EAS_FREE;
        end
      end
      default: begin
        if (!stop_lvl && !start_lvl) begin
          st_next = EAS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= EAS_IDLE;
      idx_reg <= 5'h00;
      preset_reg <= 1'b0;
      tcnt_reg <= 48'h0;
      tact_reg <= 1'b0;
      tdone_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      preset_reg <= preset_next;
      tcnt_reg <= tcnt_next;
      tact_reg <= tact_next;
      tdone_reg <= tdone_next;
    end
  end

  assign run_req = (st_reg == EAS_RUN);
  assign ramp_down = (st_reg == EAS_RAMP);
  assign coast = (st_reg == EAS_FREE) || coast_lvl;
  assign preset_sel = preset_reg;
  assign cur_pair = idx_reg;
  assign timer0_expired = tdone_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // one scan step in which the current pair's action runs
  sequence seq_eval_step;
    run_req && mode_on && start_lvl && !stop_lvl && tick_reg && ev_true && seq_len != 5'h00;
  endsequence
  sequence seq_ramp_done;
    ramp_down && !at_reference;
  endsequence
  AST_NO_ADV_OFF_TICK: assert property (run_req && !tick_reg |=> $stable(idx_reg))
    else $error("pair index moved without scan tick");
  AST_FALSE_HOLDS: assert property (run_req && cur_ev == eas_pkg::EV_FALSE
    |=> $stable(idx_reg))
    else $error("always-false event advanced");
  AST_ADVANCE: assert property (st_reg == EAS_RUN && mode_on && start_lvl && !stop_lvl
    && tick_reg && ev_true && seq_len > 5'h01 && 32'(idx_reg) + 1 < 32'(seq_len)
    |=> idx_reg == $past(idx_reg) + 5'h01)
    else $error("true event did not advance");
  AST_WRAP: assert property (st_reg == EAS_RUN && mode_on && start_lvl && !stop_lvl
    && tick_reg && ev_true && seq_len != 5'h00 && 32'(idx_reg) + 1 == 32'(seq_len)
    |=> idx_reg == 5'h00)
    else $error("sequence did not wrap");
  AST_IDLE_START: assert property (st_reg == EAS_IDLE |=> idx_reg == 5'h00)
    else $error("idle did not return to pair one");
  AST_MODE_OFF: assert property (!mode_on && st_reg != EAS_RUN |=> st_reg != EAS_RUN)
    else $error("ran with mode off");
  AST_PRESET1: assert property (run_req && mode_on && start_lvl && !stop_lvl && tick_reg
    && ev_true && seq_len != 5'h00 && cur_ac == eas_pkg::AC_PRESET1 |=> preset_sel)
    else $error("preset one not selected");
  AST_RAMP_FIRST: assert property (run_req && stop_lvl && mode_on |=> ramp_down)
    else $error("stop did not ramp down");
  AST_LATCH_CLEAR: assert property (stop_lvl |=> !latch_reg)
    else $error("latched start survived stop inverse");
  AST_TICK_PERIOD: assert property (tick_reg |=> !tick_reg)
    else $error("scan tick wider than one cycle");
  AST_PRESET0: assert property (seq_eval_step
    ##0 (cur_ac == eas_pkg::AC_PRESET0) |=> !preset_sel)
    else $error("preset zero not selected");
  AST_TIMER_ARM: assert property (seq_eval_step
    ##0 (cur_ac == eas_pkg::AC_TIMER0_START) |=> !timer0_expired)
    else $error("timer zero armed with timeout showing");
  AST_TIMEOUT_USED: assert property (seq_eval_step
    ##0 (cur_ev == eas_pkg::EV_TIMEOUT0) |=> !timer0_expired)
    else $error("timeout event not consumed");
  AST_RAMP_TO_FREE: assert property (seq_ramp_done
    |=> coast)
    else $error("ramp down did not end in coasting");
endmodule
`default_nettype wire

// file: testbench/eas_drive_model.sv
// drive speed model: reports reference reached after a settling lag
`default_nettype none
module eas_drive_model #(
  parameter int LAG = 3
) (
  // drive controls
  input wire logic clock,
  input wire logic run_req,
  input wire logic ramp_down,
  input wire logic preset_sel,
  // drive status
  output logic at_reference
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  logic sel_q = 1'b0;
  // a new target speed restarts the settling lag
  always @(posedge clock) begin
    sel_q <= preset_sel;
    if (!run_req || ramp_down || preset_sel != sel_q) cnt <= 0;
    else if (cnt < LAG) cnt <= cnt + 1;
  end
  assign at_reference = run_req && !ramp_down && cnt == LAG;
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the event/action sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [5:0] ev;
    logic [5:0] ac;
    logic pre;
    logic [7:0] mint;
  } eas_row_type;
  logic clock = 1'b0, rst_b = 1'b0, prog_we = 1'b0, mode_on = 1'b0;
  logic cmd_in1 = 1'b1, cmd_in2 = 1'b1, at_reference;
  logic [4:0] prog_addr = 5'h00, seq_len = 5'h04, cur_pair;
  logic [5:0] prog_event = 6'h00, prog_action = 6'h00;
  logic [15:0] timer0_ms = 16'h0002;
  logic [3:0] in1_func = eas_pkg::IN1_START, in2_func = eas_pkg::IN2_STOP_INV;
  logic run_req, ramp_down, coast, preset_sel, timer0_expired, scan_tick;
  int bad_count = 0;
  int n_compared = 0;
  int n;
  logic [4:0] p;
  logic exp_at_tick;
  // timer row needs at least two ticks: 20 cycles against an 8-cycle scan
  eas_row_type rows [4] = '{
    '{eas_pkg::EV_TRUE, eas_pkg::AC_PRESET0, 1'b0, 8'h01},
    '{eas_pkg::EV_ON_REF, eas_pkg::AC_TIMER0_START, 1'b0, 8'h01},
    '{eas_pkg::EV_TIMEOUT0, eas_pkg::AC_PRESET1, 1'b1, 8'h02},
    '{eas_pkg::EV_TRUE, eas_pkg::AC_NONE, 1'b1, 8'h01}
  };
  eas_top #(.SCAN_CYC(8), .MS_CYC(10)) eas_top_inst (
    .clock(clock), .rst_b(rst_b), .prog_addr(prog_addr), .prog_event(prog_event),
    .prog_action(prog_action), .prog_we(prog_we), .mode_on(mode_on), .seq_len(seq_len),
    .timer0_ms(timer0_ms), .in1_func(in1_func), .in2_func(in2_func), .cmd_in1(cmd_in1),
    .cmd_in2(cmd_in2), .at_reference(at_reference), .run_req(run_req),
    .ramp_down(ramp_down), .coast(coast), .preset_sel(preset_sel), .cur_pair(cur_pair),
    .timer0_expired(timer0_expired), .scan_tick(scan_tick)
  );
  eas_drive_model #(.LAG(3)) eas_drive_model_inst (
    .clock(clock), .run_req(run_req), .ramp_down(ramp_down),
    .preset_sel(preset_sel), .at_reference(at_reference)
  );
  initial forever #2.5 clock = ~clock;
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wcyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // lands one cycle after the tick, where the result of that scan shows
  task automatic tick();
    int i;
    i = 0;
    while (scan_tick !== 1'b1 && i < 100) begin
      wcyc(1);
      i++;
    end
    if (i == 100) begin
      bad_count++;
      results();
    end
    exp_at_tick = timer0_expired;
    wcyc(1);
  endtask
  // a wait loop that ran out of its bound ends the run as failed
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      bad_count++;
      results();
    end
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    wcyc(3);
    chk("run", run_req, 1'b0);
    chk("pair", cur_pair, 5'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      prog_addr <= 5'(i);
      prog_event <= rows[i].ev;
      prog_action <= rows[i].ac;
      prog_we <= 1'b1;
      @(posedge clock);
    end
    prog_addr <= 5'h04;
    prog_event <= eas_pkg::EV_FALSE;
    @(posedge clock);
    prog_we <= 1'b0;
    repeat (3) tick();
    chk("pair", cur_pair, 5'h00);
    n = 0;
    while (scan_tick !== 1'b1 && n < 50) begin
      wcyc(1);
      n++;
    end
    bound(n, 50);
    chk("period", 8'(n), 8'h07);
    mode_on <= 1'b1;
    for (int lap = 0; lap < 3; lap++) begin
      if (lap == 2) seq_len <= 5'h05;
      foreach (rows[i]) begin
        p = cur_pair;
        n = 0;
        while (cur_pair === p && n < 20) begin
          tick();
          n++;
        end
        bound(n, 20);
        chk("pair", cur_pair, 8'((i + 1) % seq_len));
        chk("preset", preset_sel, rows[i].pre);
        chk("ticks", 8'(n >= rows[i].mint), 8'h01);
        chk("expired", timer0_expired, 1'b0);
        if (rows[i].ev == eas_pkg::EV_TIMEOUT0) chk("expired", exp_at_tick, 1'b1);
      end
    end
    repeat (4) tick();
    chk("pair", cur_pair, 5'h04);
    $display("test sequence done");
    cmd_in2 <= 1'b0;
    wcyc(1);
    chk("ramp", ramp_down, 1'b1);
    n = 0;
    while (coast !== 1'b1 && n < 20) begin
      wcyc(1);
      n++;
    end
    bound(n, 20);
    chk("coast", coast, 1'b1);
    cmd_in1 <= 1'b0;
    cmd_in2 <= 1'b1;
    wcyc(3);
    chk("run", run_req, 1'b0);
    $display("test stop done");
    in2_func <= eas_pkg::IN2_NOOP;
    cmd_in2 <= 1'b0;
    cmd_in1 <= 1'b1;
    wcyc(3);
    chk("run", run_req, 1'b1);
    chk("ramp", ramp_down, 1'b0);
    cmd_in1 <= 1'b0;
    wcyc(3);
    chk("run", run_req, 1'b0);
    in2_func <= eas_pkg::IN2_STOP_INV;
    cmd_in2 <= 1'b1;
    in1_func <= eas_pkg::IN1_LATCHED;
    cmd_in1 <= 1'b1;
    wcyc(1);
    cmd_in1 <= 1'b0;
    wcyc(3);
    chk("run", run_req, 1'b1);
    cmd_in2 <= 1'b0;
    wcyc(3);
    chk("run", run_req, 1'b0);
    cmd_in2 <= 1'b1;
    wcyc(3);
    chk("coast", coast, 1'b0);
    in2_func <= eas_pkg::IN2_COAST_INV;
    cmd_in2 <= 1'b0;
    wcyc(1);
    chk("coast", coast, 1'b1);
    chk("run", run_req, 1'b0);
    $display("test commands done");
    results();
  end
endmodule
`default_nettype wire
